// >>> verilog/sltc_top.sv
// sltc_top: register bank and control outputs for the serial link transmitter.
// assumes one AHB-Lite master on CLK, the mode decoder supplying the
// 64b/66b flag, E and log2(F) for the current mode on the same clock,
// and sync pins arriving asynchronously.
`timescale 1ns/10ps
`default_nettype none
module sltc_top
  import sltc_pkg::*;
(
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // sync pins, active low, asynchronous
  input wire logic DEDICATED_SYNC_INPUT_N,
  input wire logic TIMESTAMP_INPUT_N,
  // same-clock inputs from the receiver and mode decoder
  input wire logic TIMESTAMP_RECEIVER_ENABLE,
  input wire logic MODE_IS_6466,
  input wire logic [7:0] MODE_E,
  input wire logic [2:0] MODE_F_LOG2,
  // link transmitter controls
  output logic LINK_RESET,
  output logic LINK_CLOCK_ENABLE,
  output logic [7:0] LANE_PD_A,
  output logic [7:0] LANE_PD_B,
  output logic SYNC_REQUEST_N,
  output logic SAMPLE_FORMAT_SELECT,
  output logic WHITENING_ENABLE,
  output logic [7:0] LINK_MODE_SELECT,
  output logic [4:0] LINK_TEST_PATTERN,
  output logic [15:0] FRAMES_PER_MULTIFRAME_MINUS_ONE
);

  // true when a byte address falls on the word of a register index
  function automatic logic hits(input logic [31:0] addr, input logic [9:0] idx);
    hits = (addr[31:12] == 20'h00000) && (addr[11:2] == idx);
  endfunction

  sltc_cfg_s cfg_reg, cfg_next;
  sltc_tx_s tx_reg, tx_next;
  logic wr_pend_reg, wr_pend_next;
  logic [31:0] wr_addr_reg, wr_addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ded_s1_reg, ded_s2_reg, ts_s1_reg, ts_s2_reg;
  logic addr_phase;
  logic [15:0] k_derived;
  sltc_sync_src_e sync_src;

  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge CLK) begin
    if (RST) begin
      ded_s1_reg <= 1'h1;
      ded_s2_reg <= 1'h1;
      ts_s1_reg <= 1'h1;
      ts_s2_reg <= 1'h1;
    end else if (CE) begin
      ded_s1_reg <= DEDICATED_SYNC_INPUT_N;
      ded_s2_reg <= ded_s1_reg;
      ts_s1_reg <= TIMESTAMP_INPUT_N;
      ts_s2_reg <= ts_s1_reg;
    end
  end

  // bus transfer capture and register writes; a write lands in its data phase
  always_comb begin
    addr_phase = HSEL && HREADY && HTRANS[1];
    cfg_next = cfg_reg;
    wr_pend_next = addr_phase && HWRITE;
    wr_addr_next = addr_phase ? HADDR : wr_addr_reg;
    // relies on software; settings are stored whenever written
    if (wr_pend_reg) begin
      if (hits(wr_addr_reg, SLTC_IDX_LINK_ENABLE)) begin
        cfg_next.link_enable = HWDATA[0];
      end else if (hits(wr_addr_reg, SLTC_IDX_LINK_MODE)) begin
        cfg_next.link_mode_select = HWDATA[7:0];
      end else if (hits(wr_addr_reg, SLTC_IDX_MULTIFRAME_LEN)) begin
        cfg_next.frames_per_multiframe_minus_one = HWDATA[7:0];
      end else if (hits(wr_addr_reg, SLTC_IDX_SOFT_SYNC)) begin
        cfg_next.software_sync_request_n = HWDATA[0];
      end else if (hits(wr_addr_reg, SLTC_IDX_LINK_CONTROL)) begin
        cfg_next.link_control = HWDATA[4:0];
      end else if (hits(wr_addr_reg, SLTC_IDX_TEST_PATTERN)) begin
        cfg_next.link_test_pattern = HWDATA[4:0];
      end
    end
  end

  // read data built from the next values, so a read right behind a write sees it
  always_comb begin
    rdata_next = rdata_reg;
    if (addr_phase && !HWRITE) begin
      if (hits(HADDR, SLTC_IDX_LINK_ENABLE)) begin
        rdata_next = {31'h00000000, cfg_next.link_enable};
      end else if (hits(HADDR, SLTC_IDX_LINK_MODE)) begin
        rdata_next = {24'h000000, cfg_next.link_mode_select};
      end else if (hits(HADDR, SLTC_IDX_MULTIFRAME_LEN)) begin
        rdata_next = {24'h000000, cfg_next.frames_per_multiframe_minus_one};
      end else if (hits(HADDR, SLTC_IDX_SOFT_SYNC)) begin
        rdata_next = {31'h00000000, cfg_next.software_sync_request_n};
      end else if (hits(HADDR, SLTC_IDX_LINK_CONTROL)) begin
        rdata_next = {27'h0000000, cfg_next.link_control};
      end else if (hits(HADDR, SLTC_IDX_TEST_PATTERN)) begin
        rdata_next = {27'h0000000, cfg_next.link_test_pattern};
      end else begin
        rdata_next = 32'h00000000; // unmapped reads zero, still OKAY
      end
    end
  end

  // bus and configuration registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg_reg <= SLTC_CFG_RESET;
      wr_pend_reg <= 1'h0;
      wr_addr_reg <= 32'h00000000;
      rdata_reg <= 32'h00000000;
      HREADYOUT <= 1'h1;
      HRESP <= 1'h0;
    end else if (CE) begin
      cfg_reg <= cfg_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rdata_reg <= rdata_next;
      HREADYOUT <= 1'h1; // zero wait states, every transfer
      HRESP <= 1'h0;
    end
  end
  assign HRDATA = rdata_reg;

  // transmitter settings; outputs lag the registers by one cycle
  always_comb begin
    sync_src = sltc_sync_src_e'(cfg_reg.link_control[SLTC_CTL_SYNC_HI:SLTC_CTL_SYNC_LO]);
    // power-of-two F keeps the divide a shift
    k_derived = (SLTC_K_SCALE * {8'h00, MODE_E}) >> MODE_F_LOG2;
    tx_next.link_mode_select = cfg_reg.link_mode_select;
    tx_next.link_test_pattern = cfg_reg.link_test_pattern;
    tx_next.sample_format_select = cfg_reg.link_control[SLTC_CTL_FORMAT];
    // 64b/66b always scrambles
    tx_next.whitening_enable = MODE_IS_6466 || cfg_reg.link_control[SLTC_CTL_WHITEN];
    if (MODE_IS_6466) begin
      tx_next.frames_per_multiframe_minus_one = k_derived - 16'h0001;
    end else begin
      tx_next.frames_per_multiframe_minus_one =
        {8'h00, cfg_reg.frames_per_multiframe_minus_one};
    end
    // the software bit requests in every source setting
    tx_next.sync_request_n = cfg_reg.software_sync_request_n;
    case (sync_src)
      SLTC_SRC_DEDICATED: begin
        tx_next.sync_request_n = tx_next.sync_request_n && ded_s2_reg;
      end
      SLTC_SRC_TIMESTAMP: begin
        // the pin counts only while its receiver is on
        tx_next.sync_request_n = tx_next.sync_request_n &&
          (ts_s2_reg || !TIMESTAMP_RECEIVER_ENABLE);
      end
      default: begin
        tx_next.sync_request_n = cfg_reg.software_sync_request_n;
      end
    endcase
    // lane map; undefined for wide modes, so no mode check is made here
    if (!cfg_reg.link_enable) begin
      tx_next.lane_pd_a = SLTC_PD_ALL;
      tx_next.lane_pd_b = SLTC_PD_ALL;
    end else if (cfg_reg.link_control[SLTC_CTL_UPPER]) begin
      tx_next.lane_pd_a = SLTC_PD_UPPER_USED;
      tx_next.lane_pd_b = SLTC_PD_UPPER_USED;
    end else begin
      tx_next.lane_pd_a = SLTC_PD_LOWER_USED;
      tx_next.lane_pd_b = SLTC_PD_LOWER_USED;
    end
    tx_next.link_reset = !cfg_reg.link_enable;
    tx_next.link_clock_enable = cfg_reg.link_enable;
  end

  // transmitter output flops; reset matches the enabled reset configuration
  always_ff @(posedge CLK) begin
    if (RST) begin
      tx_reg <= '{
        link_reset: 1'h0,
        link_clock_enable: 1'h1,
        lane_pd_a: SLTC_PD_LOWER_USED,
        lane_pd_b: SLTC_PD_LOWER_USED,
        sync_request_n: 1'h1,
        sample_format_select: 1'h1,
        whitening_enable: 1'h1,
        link_mode_select: SLTC_RST_LINK_MODE,
        link_test_pattern: SLTC_RST_TEST_PATTERN,
        frames_per_multiframe_minus_one: {8'h00, SLTC_RST_MULTIFRAME_LEN}
      };
    end else if (CE) begin
      tx_reg <= tx_next;
    end
  end
  assign LINK_RESET = tx_reg.link_reset;
  assign LINK_CLOCK_ENABLE = tx_reg.link_clock_enable;
  assign LANE_PD_A = tx_reg.lane_pd_a;
  assign LANE_PD_B = tx_reg.lane_pd_b;
  assign SYNC_REQUEST_N = tx_reg.sync_request_n;
  assign SAMPLE_FORMAT_SELECT = tx_reg.sample_format_select;
  assign WHITENING_ENABLE = tx_reg.whitening_enable;
  assign LINK_MODE_SELECT = tx_reg.link_mode_select;
  assign LINK_TEST_PATTERN = tx_reg.link_test_pattern;
  assign FRAMES_PER_MULTIFRAME_MINUS_ONE = tx_reg.frames_per_multiframe_minus_one;

  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  chk_mode_reset_value: assert property (
    $past(RST) |-> cfg_reg.link_mode_select == SLTC_RST_LINK_MODE && LINK_MODE_SELECT == 8'h02)
    else $error("link mode not 0x02 after reset");
  chk_frame_count_reg: assert property (
    CE && !MODE_IS_6466 |=> FRAMES_PER_MULTIFRAME_MINUS_ONE ==
      {8'h00, $past(cfg_reg.frames_per_multiframe_minus_one)})
    else $error("frame count does not follow register");
  chk_frame_count_derived: assert property (
    CE && MODE_IS_6466 |=> FRAMES_PER_MULTIFRAME_MINUS_ONE ==
      16'(((32'd256 * $past(MODE_E)) >> $past(MODE_F_LOG2)) - 32'd1))
    else $error("frame count not 256*E/F minus one");
  chk_soft_sync_req: assert property (
    CE && !cfg_reg.software_sync_request_n |=> !SYNC_REQUEST_N)
    else $error("software request not seen");
  chk_sync_write_path: assert property (
    CE && wr_pend_reg && hits(wr_addr_reg, SLTC_IDX_SOFT_SYNC) && !HWDATA[0]
      ##1 CE |=> !SYNC_REQUEST_N)
    else $error("write of 0 to sync bit did not request");
  chk_pin_holds_req: assert property (
    CE && ded_s2_reg == 1'h0 && sync_src == SLTC_SRC_DEDICATED |=> !SYNC_REQUEST_N)
    else $error("low dedicated pin released request");
  chk_software_source: assert property (
    CE && sync_src == SLTC_SRC_SOFTWARE |=> SYNC_REQUEST_N == $past(cfg_reg.software_sync_request_n))
    else $error("software source not pin-free");
  chk_lane_map_low: assert property (
    CE && cfg_reg.link_enable && !cfg_reg.link_control[SLTC_CTL_UPPER]
      |=> LANE_PD_A == 8'hF0 && LANE_PD_B == 8'hF0)
    else $error("lower lane map wrong");
  chk_lane_map_up: assert property (
    CE && cfg_reg.link_enable && cfg_reg.link_control[SLTC_CTL_UPPER]
      |=> LANE_PD_A == 8'h0F && LANE_PD_B == 8'h0F)
    else $error("upper lane map wrong");
  chk_format_bit: assert property (
    CE |=> SAMPLE_FORMAT_SELECT == $past(cfg_reg.link_control[SLTC_CTL_FORMAT]))
    else $error("sample format not following bit");
  chk_scramble_forced: assert property (
    CE && MODE_IS_6466 |=> WHITENING_ENABLE)
    else $error("64b/66b mode not scrambling");
  chk_disabled_link: assert property (
    CE && !cfg_reg.link_enable |=> LINK_RESET && !LINK_CLOCK_ENABLE &&
      LANE_PD_A == 8'hFF && LANE_PD_B == 8'hFF)
    else $error("disabled link not held down");
  chk_bus_okay: assert property (
    HREADYOUT && !HRESP)
    else $error("bus answer not OKAY with no wait");

endmodule
`default_nettype wire

// >>> verilog/sltc_pkg.sv
// sltc_pkg: constants and carrier types for the serial link transmit configuration bank.
// assumes a 32-bit AHB-Lite slave with one register per aligned word (byte address = 4 * index).
`default_nettype none
package sltc_pkg;
  // register indexes; the byte address is four times the index
  localparam logic [9:0] SLTC_IDX_LINK_ENABLE = 10'h200;
  localparam logic [9:0] SLTC_IDX_LINK_MODE = 10'h201;
  localparam logic [9:0] SLTC_IDX_MULTIFRAME_LEN = 10'h202;
  localparam logic [9:0] SLTC_IDX_SOFT_SYNC = 10'h203;
  localparam logic [9:0] SLTC_IDX_LINK_CONTROL = 10'h204;
  localparam logic [9:0] SLTC_IDX_TEST_PATTERN = 10'h205;
  // reset values
  localparam logic SLTC_RST_LINK_ENABLE = 1'h1;
  localparam logic [7:0] SLTC_RST_LINK_MODE = 8'h02;
  localparam logic [7:0] SLTC_RST_MULTIFRAME_LEN = 8'h1F;
  localparam logic SLTC_RST_SOFT_SYNC = 1'h1;
  localparam logic [4:0] SLTC_RST_LINK_CONTROL = 5'h03;
  localparam logic [4:0] SLTC_RST_TEST_PATTERN = 5'h00;
  // link control field positions
  localparam int SLTC_CTL_WHITEN = 0;
  localparam int SLTC_CTL_FORMAT = 1;
  localparam int SLTC_CTL_SYNC_LO = 2;
  localparam int SLTC_CTL_SYNC_HI = 3;
  localparam int SLTC_CTL_UPPER = 4;
  // frames per multiframe in 64b/66b modes is this scale times E over F
  localparam logic [15:0] SLTC_K_SCALE = 16'h0100;
  // lane power-down patterns, one bit per lane, 1 = powered down
  localparam logic [7:0] SLTC_PD_ALL = 8'hFF;
  localparam logic [7:0] SLTC_PD_LOWER_USED = 8'hF0;
  localparam logic [7:0] SLTC_PD_UPPER_USED = 8'h0F;
  // sync source selection codes
  typedef enum logic [1:0] {
    SLTC_SRC_DEDICATED,
    SLTC_SRC_TIMESTAMP,
    SLTC_SRC_SOFTWARE,
    SLTC_SRC_RESERVED
  } sltc_sync_src_e;
  // software-visible configuration
  typedef struct packed {
    logic link_enable;
    logic [7:0] link_mode_select;
    logic [7:0] frames_per_multiframe_minus_one;
    logic software_sync_request_n;
    logic [4:0] link_control;
    logic [4:0] link_test_pattern;
  } sltc_cfg_s;
  localparam sltc_cfg_s SLTC_CFG_RESET = '{
    link_enable: SLTC_RST_LINK_ENABLE,
    link_mode_select: SLTC_RST_LINK_MODE,
    frames_per_multiframe_minus_one: SLTC_RST_MULTIFRAME_LEN,
    software_sync_request_n: SLTC_RST_SOFT_SYNC,
    link_control: SLTC_RST_LINK_CONTROL,
    link_test_pattern: SLTC_RST_TEST_PATTERN
  };
  // settings handed to the link transmitter
  typedef struct packed {
    logic link_reset;
    logic link_clock_enable;
    logic [7:0] lane_pd_a;
    logic [7:0] lane_pd_b;
    logic sync_request_n;
    logic sample_format_select;
    logic whitening_enable;
    logic [7:0] link_mode_select;
    logic [4:0] link_test_pattern;
    logic [15:0] frames_per_multiframe_minus_one;
  } sltc_tx_s;
endpackage
`default_nettype wire

// >>> dv/sltc_rx_model.sv
// sltc_rx_model: far-side receiver model driving the two active-low sync pins.
// assumes the bench says when the receiver wants a resync on each pin.
`timescale 1ns/10ps
`default_nettype none
module sltc_rx_model (
  // clock of the bench
  input wire logic clk,
  // resync wishes from the bench
  input wire logic want_ded,
  input wire logic want_ts,
  // sync pins toward the device, active low
  output logic ded_n,
  output logic ts_n
);
  // pins move well off the edge: the device treats them as asynchronous;
  // they settle at the first edge, long before reset lets the synchronisers go
  always @(posedge clk) begin
    ded_n <= #1.3 !want_ded;
    ts_n <= #1.3 !want_ts;
  end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// tb_top: register-level bench for the link transmit configuration bank.
// assumes a zero-wait-state slave and the receiver model on the sync pins.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("ERROR %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module tb_top import sltc_pkg::*;;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic ce = 1'b1;
  logic HWRITE = 1'b0;
  logic [1:0] HTRANS = 2'h0;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic rx_en = 1'b0;
  logic m6466 = 1'b0;
  logic [7:0] mode_e = 8'h01;
  logic [2:0] f_log2 = 3'h0;
  logic want_ded = 1'b0;
  logic want_ts = 1'b0;
  logic ded_n, ts_n, ready, resp;
  logic [31:0] rdata;
  wire sltc_tx_s tx;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  // reset values and writable masks, one word per register from link_enable up
  logic [31:0] rst_tab [6] = '{32'h1, 32'h2, 32'h1F, 32'h1, 32'h3, 32'h0};
  logic [31:0] msk [6] = '{32'h1, 32'hFF, 32'hFF, 32'h1, 32'h1F, 32'h1F};
  // sync cases: src[6:5] soft[4] ded_low[3] ts_low[2] rx_en[1] expected[0]
  // the timestamp pin only counts while its receiver is on; source 3 acts as software
  logic [6:0] sy [12] = '{7'h1A, 7'h5B, 7'h36, 7'h35, 7'h33, 7'h3B, 7'h11, 7'h00,
    7'h20, 7'h40, 7'h60, 7'h7B};

  // 250 MHz clock
  always #2 CLK = ~CLK;

  sltc_top u_dut (
    .CLK(CLK), .RST(RST), .CE(ce), .HSEL(1'b1), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(ready), .HRDATA(rdata),
    .HREADYOUT(ready), .HRESP(resp), .DEDICATED_SYNC_INPUT_N(ded_n),
    .TIMESTAMP_INPUT_N(ts_n), .TIMESTAMP_RECEIVER_ENABLE(rx_en), .MODE_IS_6466(m6466),
    .MODE_E(mode_e), .MODE_F_LOG2(f_log2), .LINK_RESET(tx.link_reset),
    .LINK_CLOCK_ENABLE(tx.link_clock_enable), .LANE_PD_A(tx.lane_pd_a),
    .LANE_PD_B(tx.lane_pd_b), .SYNC_REQUEST_N(tx.sync_request_n),
    .SAMPLE_FORMAT_SELECT(tx.sample_format_select),
    .WHITENING_ENABLE(tx.whitening_enable), .LINK_MODE_SELECT(tx.link_mode_select),
    .LINK_TEST_PATTERN(tx.link_test_pattern),
    .FRAMES_PER_MULTIFRAME_MINUS_ONE(tx.frames_per_multiframe_minus_one)
  );

  sltc_rx_model u_rx (
    .clk(CLK), .want_ded(want_ded), .want_ts(want_ts), .ded_n(ded_n), .ts_n(ts_n)
  );

  // single write: address phase held until ready, then data phase until ready
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    HTRANS <= 2'h2;
    HWRITE <= 1'b1;
    HADDR <= {20'h0, idx, 2'h0};
    do @(posedge CLK); while (ready !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (ready !== 1'b1);
  endtask

  // single read; data taken at the edge that ends the data phase
  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    HTRANS <= 2'h2;
    HWRITE <= 1'b0;
    HADDR <= {20'h0, idx, 2'h0};
    do @(posedge CLK); while (ready !== 1'b1);
    HTRANS <= 2'h0;
    do @(posedge CLK); while (ready !== 1'b1);
    `CHK(rdata, exp)
    `CHK(resp, 1'b0)
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
  endtask

  task automatic stop_test();
    if (failures == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("ERROR %0t: timeout", $time);
      stop_test();
    end
  end

  initial begin
    tick(8);
    RST <= 1'b0;
    tick(1);
    // reset values of every register and of the lane, frame-count, format, scrambling and sync outputs
    for (int i = 0; i < 6; i++) begin
      rd(SLTC_IDX_LINK_ENABLE + 10'(i), rst_tab[i]);
    end
    `CHK(tx.lane_pd_a, SLTC_PD_LOWER_USED)
    `CHK(tx.lane_pd_b, SLTC_PD_LOWER_USED)
    `CHK(tx.frames_per_multiframe_minus_one, 16'h001F)
    `CHK({tx.sample_format_select, tx.whitening_enable}, 2'h3)
    `CHK(tx.sync_request_n, 1'b1)
    // disable before touching settings; the link must fall into reset
    wr(SLTC_IDX_LINK_ENABLE, 32'h0);
    tick(2);
    `CHK({tx.link_reset, tx.link_clock_enable}, 2'h2)
    `CHK({tx.lane_pd_a, tx.lane_pd_b}, {SLTC_PD_ALL, SLTC_PD_ALL})
    // all ones into each register above link_enable reads back only the implemented bits
    for (int i = 1; i < 6; i++) begin
      wr(SLTC_IDX_LINK_ENABLE + 10'(i), 32'hFFFFFFFF);
      rd(SLTC_IDX_LINK_ENABLE + 10'(i), msk[i]);
    end
    wr(10'h206, 32'hFFFFFFFF);
    rd(10'h206, 32'h0);
    tick(1);
    `CHK({tx.link_mode_select, tx.link_test_pattern}, 13'h1FFF)
    // frame count from the register, then from E and F in 64b/66b modes
    wr(SLTC_IDX_MULTIFRAME_LEN, 32'h0F);
    tick(2);
    `CHK(tx.frames_per_multiframe_minus_one, 16'h000F)
    m6466 <= 1'b1;
    mode_e <= 8'h03;
    f_log2 <= 3'h2;
    wr(SLTC_IDX_LINK_CONTROL, 32'h1C);
    tick(2);
    `CHK(tx.frames_per_multiframe_minus_one, 16'h00BF)
    `CHK(tx.whitening_enable, 1'b1)
    `CHK(tx.sample_format_select, 1'b0)
    m6466 <= 1'b0;
    tick(2);
    `CHK(tx.whitening_enable, 1'b0)
    `CHK(tx.frames_per_multiframe_minus_one, 16'h000F)
    // enable with upper lanes, then back to lower lanes
    wr(SLTC_IDX_LINK_ENABLE, 32'h1);
    tick(2);
    `CHK({tx.link_reset, tx.link_clock_enable}, 2'h1)
    `CHK({tx.lane_pd_a, tx.lane_pd_b}, {SLTC_PD_UPPER_USED, SLTC_PD_UPPER_USED})
    wr(SLTC_IDX_LINK_CONTROL, 32'h0C);
    tick(2);
    `CHK({tx.lane_pd_a, tx.lane_pd_b}, {SLTC_PD_LOWER_USED, SLTC_PD_LOWER_USED})
    // every sync source against software bit, pins and receiver enable
    for (int i = 0; i < 12; i++) begin
      want_ded <= sy[i][3];
      want_ts <= sy[i][2];
      rx_en <= sy[i][1];
      wr(SLTC_IDX_SOFT_SYNC, {31'h0, sy[i][4]});
      wr(SLTC_IDX_LINK_CONTROL, {27'h0, 1'b0, sy[i][6:5], 2'h3});
      tick(6);
      `CHK(tx.sync_request_n, sy[i][0])
    end
    // clock enable low freezes the link outputs although the mode flag moves
    ce <= 1'b0;
    m6466 <= 1'b1;
    tick(4);
    `CHK(tx.frames_per_multiframe_minus_one, 16'h000F)
    ce <= 1'b1;
    tick(2);
    `CHK(tx.frames_per_multiframe_minus_one, 16'h00BF)
    m6466 <= 1'b0;
    // reset in mid-run brings back the reset configuration
    RST <= 1'b1;
    tick(2);
    RST <= 1'b0;
    tick(1);
    rd(SLTC_IDX_LINK_MODE, 32'h2);
    `CHK(tx.link_mode_select, SLTC_RST_LINK_MODE)
    `CHK(tx.frames_per_multiframe_minus_one, 16'h001F)
    stop_test();
  end
endmodule
`default_nettype wire
